// ===== hw/uifl_pkg.sv
// Purpose: shared constants and types of the usb interrupt flag logic
// Assumes: 100 MHz system clock, engine events arrive on the same clock
// Notes: register offsets index an 8-bit register port
`default_nettype none
package uifl_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int IDLE_TIME_US = 3000; // 3 ms of constant idle
  localparam int IDLE_CYCLES = IDLE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int TURN_BIT_LIMIT = 16; // bit times after eop before timeout
  localparam int WAKE_SYNC_CYCLES = 4;
  localparam int TXN_FIFO_DEPTH = 4;

  localparam logic [2:0] ADDR_STAT_FLAGS = 3'h0;
  localparam logic [2:0] ADDR_STAT_EN = 3'h1;
  localparam logic [2:0] ADDR_ERR_FLAGS = 3'h2;
  localparam logic [2:0] ADDR_ERR_EN = 3'h3;
  localparam logic [2:0] ADDR_TXN_STATUS = 3'h4;
  localparam logic [2:0] ADDR_DEV_ADDR = 3'h5;
  localparam logic [2:0] ADDR_CTRL = 3'h6;

  localparam int BIT_FRAME_START = 6;
  localparam int BIT_STALL_SENT = 5;
  localparam int BIT_BUS_IDLE = 4;
  localparam int BIT_TXN_DONE = 3;
  localparam int BIT_BUS_ACT = 2;
  localparam int BIT_ERR_SUM = 1;
  localparam int BIT_BUS_RESET = 0;
  localparam int BIT_STUFF = 7;
  localparam int BIT_TURNAROUND = 4;
  localparam int BIT_PARTIAL = 3;
  localparam int BIT_DATA_CRC = 2;
  localparam int BIT_TOKEN_CRC = 1;
  localparam int BIT_PID_CHECK = 0;
  localparam int BIT_SUSPEND = 0;

  localparam logic [7:0] STAT_IMPL_MASK = 8'h7F;
  localparam logic [7:0] STAT_SW_MASK = 8'h7D;
  localparam logic [7:0] ERR_IMPL_MASK = 8'h9F;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [6:0] DEV_ADDR_RST = 7'h00;

  typedef enum logic [1:0] {
    TOK_OUT = 2'h0,
    TOK_IN = 2'h1,
    TOK_SETUP = 2'h3,
    TOK_OTHER = 2'h2
  } uifl_token_t;

  typedef enum logic {
    ACT_WAIT_IDLE = 1'b0,
    ACT_ARMED = 1'b1
  } uifl_act_state_t;

  typedef enum logic {
    TA_IDLE = 1'b0,
    TA_WAIT = 1'b1
  } uifl_ta_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } uifl_bus_req_t;

  typedef struct packed {
    logic frame_start;
    logic stall_sent;
    logic bus_reset;
    logic bus_active;
    logic bus_idle_level;
  } uifl_stat_ev_t;

  typedef struct packed {
    logic stuff;
    logic partial_byte;
    logic data_crc;
    logic token_crc;
    logic pid_check;
    logic eop;
    logic bit_tick;
    logic resp_start;
  } uifl_err_ev_t;

  typedef struct packed {
    logic valid;
    uifl_token_t token;
    logic [7:0] info;
  } uifl_txn_t;
endpackage
`default_nettype wire

// ===== hw/uifl_top.sv
// Purpose: two-level usb interrupt flags, enables, summary and request
// Assumes: engine event inputs are one-cycle pulses on clk_sys, except bus_idle_level, a level held while the bus is idle
// Notes: register port is 8 bits wide, read data valid one cycle after rd
//
// The placing of the registers and strobed register access were decided locally.
`default_nettype none
module uifl_top
  import uifl_pkg::*;
#(
  parameter int unsigned IDLE_CYC = IDLE_CYCLES,
  parameter int unsigned FIFO_DEPTH = TXN_FIFO_DEPTH
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronous reset
  input wire uifl_bus_req_t bus_req, // register port request
  output logic [7:0] rd_data, // read data, cycle after rd
  input wire uifl_stat_ev_t stat_ev, // status events from engine
  input wire uifl_err_ev_t err_ev, // error events from engine
  input wire uifl_txn_t txn_in, // finished transaction entry
  output logic txn_fifo_full, // no room for another entry
  output logic [6:0] device_address, // device address register
  output logic suspend_control, // module suspended
  output logic usb_irq_request // single request to cpu
);
  localparam int IDLE_W = $clog2(IDLE_CYC + 1);
  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam int TA_W = $clog2(TURN_BIT_LIMIT + 2);
  localparam int WAKE_W = $clog2(WAKE_SYNC_CYCLES + 1);

  logic [7:0] status_event_flags;
  logic [7:0] status_event_enables;
  logic [7:0] error_event_flags;
  logic [7:0] error_event_enables;
  logic error_summary_bit;
  logic wr_stat, wr_err, act_clear_blocked;
  logic [7:0] stat_hw_set, stat_sw_set, stat_sw_clr, err_hw_set, err_sw_clr;
  logic [7:0] stat_view;
  logic [IDLE_W-1:0] idle_cnt;
  logic idle_event;
  uifl_act_state_t act_state;
  logic act_fire;
  uifl_ta_state_t ta_state;
  logic [TA_W-1:0] ta_cnt;
  logic ta_timeout;
  logic [WAKE_W-1:0] wake_cnt;
  uifl_txn_t txn_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] txn_rd_ptr, txn_wr_ptr;
  logic [CNT_W-1:0] txn_count, next_txn_count;
  logic txn_push, txn_pop;
  uifl_txn_t txn_head;

  assign wr_stat = bus_req.wr && bus_req.addr == ADDR_STAT_FLAGS;
  assign wr_err = bus_req.wr && bus_req.addr == ADDR_ERR_FLAGS;
  assign stat_view = status_event_flags | {6'h00, error_summary_bit, 1'b0};
  assign txn_head = txn_mem[txn_rd_ptr];

  // transaction status fifo
  assign txn_push = txn_in.valid && txn_count != CNT_W'(FIFO_DEPTH);
  assign txn_pop = wr_stat && !bus_req.wdata[BIT_TXN_DONE] && status_event_flags[BIT_TXN_DONE]
                   && txn_count != '0 && txn_head.token != TOK_OTHER;
  always_comb begin
    next_txn_count = txn_count;
    if (txn_push && !txn_pop) begin
      next_txn_count = txn_count + CNT_W'(1);
    end else if (txn_pop && !txn_push) begin
      next_txn_count = txn_count - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (txn_push) begin
      txn_mem[txn_wr_ptr] <= txn_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      txn_rd_ptr <= '0;
      txn_wr_ptr <= '0;
      txn_count <= '0;
      txn_fifo_full <= 1'b0;
    end else begin
      if (txn_push) begin
        txn_wr_ptr <= (txn_wr_ptr == PTR_W'(FIFO_DEPTH - 1)) ? '0 : txn_wr_ptr + PTR_W'(1);
      end
      if (txn_pop) begin
        txn_rd_ptr <= (txn_rd_ptr == PTR_W'(FIFO_DEPTH - 1)) ? '0 : txn_rd_ptr + PTR_W'(1);
      end
      txn_count <= next_txn_count;
      txn_fifo_full <= next_txn_count == CNT_W'(FIFO_DEPTH);
    end
  end

  // idle detector: counter saturates so the event fires once per idle stretch
  assign idle_event = stat_ev.bus_idle_level && idle_cnt == IDLE_W'(IDLE_CYC - 1);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      idle_cnt <= '0;
    end else if (!stat_ev.bus_idle_level) begin
      idle_cnt <= '0;
    end else if (idle_cnt != IDLE_W'(IDLE_CYC)) begin
      idle_cnt <= idle_cnt + IDLE_W'(1);
    end
  end

  // activity is armed only by an idle event, so traffic cannot re-raise it
  assign act_fire = act_state == ACT_ARMED && stat_ev.bus_active;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      act_state <= ACT_WAIT_IDLE;
    end else begin
      case (act_state)
        ACT_WAIT_IDLE: begin
          if (idle_event) begin
            act_state <= ACT_ARMED;
          end
        end
        ACT_ARMED: begin
          if (act_fire) begin
            act_state <= ACT_WAIT_IDLE;
          end
        end
        default: begin
          act_state <= ACT_WAIT_IDLE;
        end
      endcase
    end
  end

  // suspend control and wake-up synchronisation window
  assign act_clear_blocked = suspend_control || wake_cnt != '0;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      suspend_control <= 1'b0;
      wake_cnt <= '0;
    end else begin
      if (bus_req.wr && bus_req.addr == ADDR_CTRL) begin
        suspend_control <= bus_req.wdata[BIT_SUSPEND];
      end
      if (suspend_control && bus_req.wr && bus_req.addr == ADDR_CTRL && !bus_req.wdata[BIT_SUSPEND]) begin
        wake_cnt <= WAKE_W'(WAKE_SYNC_CYCLES);
      end else if (wake_cnt != '0) begin
        wake_cnt <= wake_cnt - WAKE_W'(1);
      end
    end
  end

  // turnaround timer counts bit strobes after eop until a response starts
  assign ta_timeout = ta_state == TA_WAIT && ta_cnt > TA_W'(TURN_BIT_LIMIT);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ta_state <= TA_IDLE;
      ta_cnt <= '0;
    end else begin
      case (ta_state)
        TA_IDLE: begin
          ta_cnt <= '0;
          if (err_ev.eop) begin
            ta_state <= TA_WAIT;
          end
        end
        TA_WAIT: begin
          if (err_ev.resp_start || ta_timeout) begin
            ta_state <= TA_IDLE;
          end else if (err_ev.eop) begin
            // timeout counts from the latest eop, not a stale one
            ta_cnt <= '0;
          end else if (err_ev.bit_tick) begin
            ta_cnt <= ta_cnt + TA_W'(1);
          end
        end
        default: begin
          ta_state <= TA_IDLE;
        end
      endcase
    end
  end

  // status flags: hardware set wins over a software clear in the same cycle
  always_comb begin
    stat_hw_set = 8'h00;
    stat_hw_set[BIT_FRAME_START] = stat_ev.frame_start;
    stat_hw_set[BIT_STALL_SENT] = stat_ev.stall_sent;
    stat_hw_set[BIT_BUS_IDLE] = idle_event;
    stat_hw_set[BIT_TXN_DONE] = txn_push || (txn_pop && txn_count > CNT_W'(1));
    stat_hw_set[BIT_BUS_ACT] = act_fire;
    stat_hw_set[BIT_BUS_RESET] = stat_ev.bus_reset;
    stat_sw_set = wr_stat ? (bus_req.wdata & STAT_SW_MASK) : 8'h00;
    stat_sw_clr = wr_stat ? (~bus_req.wdata & STAT_SW_MASK) : 8'h00;
    if (act_clear_blocked) begin
      stat_sw_clr[BIT_BUS_ACT] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_event_flags <= REG_RST;
    end else begin
      status_event_flags <= ((status_event_flags & ~stat_sw_clr) | stat_sw_set | stat_hw_set) & STAT_SW_MASK;
    end
  end

  // error flags: clear-only from software, set at detection
  always_comb begin
    err_hw_set = 8'h00;
    err_hw_set[BIT_STUFF] = err_ev.stuff;
    err_hw_set[BIT_TURNAROUND] = ta_timeout;
    err_hw_set[BIT_PARTIAL] = err_ev.partial_byte;
    err_hw_set[BIT_DATA_CRC] = err_ev.data_crc;
    err_hw_set[BIT_TOKEN_CRC] = err_ev.token_crc;
    err_hw_set[BIT_PID_CHECK] = err_ev.pid_check;
    err_sw_clr = wr_err ? (~bus_req.wdata & ERR_IMPL_MASK) : 8'h00;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      error_event_flags <= REG_RST;
    end else begin
      error_event_flags <= ((error_event_flags & ~err_sw_clr) | err_hw_set) & ERR_IMPL_MASK;
    end
  end

  // enables and device address
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_event_enables <= REG_RST;
      error_event_enables <= REG_RST;
    end else if (bus_req.wr) begin
      if (bus_req.addr == ADDR_STAT_EN) begin
        status_event_enables <= bus_req.wdata & STAT_IMPL_MASK;
      end
      if (bus_req.addr == ADDR_ERR_EN) begin
        error_event_enables <= bus_req.wdata & ERR_IMPL_MASK;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      device_address <= DEV_ADDR_RST;
    end else if (stat_ev.bus_reset) begin
      device_address <= DEV_ADDR_RST;
    end else if (bus_req.wr && bus_req.addr == ADDR_DEV_ADDR) begin
      device_address <= bus_req.wdata[6:0];
    end
  end

  // summary and request are registered, one cycle behind their sources
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      error_summary_bit <= 1'b0;
      usb_irq_request <= 1'b0;
    end else begin
      error_summary_bit <= |(error_event_flags & error_event_enables);
      usb_irq_request <= |(stat_view & status_event_enables);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_STAT_FLAGS: rd_data <= stat_view;
        ADDR_STAT_EN: rd_data <= status_event_enables;
        ADDR_ERR_FLAGS: rd_data <= error_event_flags;
        ADDR_ERR_EN: rd_data <= error_event_enables;
        ADDR_TXN_STATUS: rd_data <= (txn_count != '0) ? txn_head.info : 8'h00;
        ADDR_DEV_ADDR: rd_data <= {1'b0, device_address};
        ADDR_CTRL: rd_data <= {7'h00, suspend_control};
        default: rd_data <= 8'h00;
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_frame_start;
    stat_ev.frame_start |=> status_event_flags[BIT_FRAME_START];
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame start flag not set");

  property p_stall_sent;
    stat_ev.stall_sent |=> status_event_flags[BIT_STALL_SENT];
  endproperty
  a_stall_sent: assert property (p_stall_sent) else $error("stall flag not set");

  property p_idle;
    (stat_ev.bus_idle_level && idle_cnt == IDLE_W'(IDLE_CYC - 1)) |=> status_event_flags[BIT_BUS_IDLE];
  endproperty
  a_idle: assert property (p_idle) else $error("idle flag not set after idle time");

  property p_txn_push;
    (txn_push && txn_count == '0) |=> status_event_flags[BIT_TXN_DONE] && txn_head.info == $past(txn_in.info);
  endproperty
  a_txn_push: assert property (p_txn_push) else $error("transaction entry not visible");

  property p_txn_pop;
    (txn_pop && !txn_push) |=> txn_count == $past(txn_count) - CNT_W'(1);
  endproperty
  a_txn_pop: assert property (p_txn_pop) else $error("fifo did not advance");

  property p_act_once;
    (act_state == ACT_WAIT_IDLE && !wr_stat) |=> !$rose(status_event_flags[BIT_BUS_ACT]);
  endproperty
  a_act_once: assert property (p_act_once) else $error("activity raised without idle");

  property p_act_block;
    (wr_stat && bus_req.wdata[BIT_BUS_ACT] == 1'b0 && suspend_control && status_event_flags[BIT_BUS_ACT])
      |=> status_event_flags[BIT_BUS_ACT];
  endproperty
  a_act_block: assert property (p_act_block) else $error("activity cleared while suspended");

  property p_err_sum;
    ##1 error_summary_bit == |($past(error_event_flags) & $past(error_event_enables));
  endproperty
  a_err_sum: assert property (p_err_sum) else $error("error summary mismatch");

  property p_bus_reset;
    stat_ev.bus_reset |=> status_event_flags[BIT_BUS_RESET] && device_address == 7'h00;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("bus reset not handled");

  property p_err_hold;
    (error_event_flags[BIT_DATA_CRC] && !wr_err) |=> error_event_flags[BIT_DATA_CRC];
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped");

  property p_turnaround;
    $rose(error_event_flags[BIT_TURNAROUND]) |-> $past(ta_cnt) == TA_W'(TURN_BIT_LIMIT + 1);
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("turnaround timeout count wrong");

  property p_irq;
    ##1 usb_irq_request == |($past(stat_view) & $past(status_event_enables));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request mismatch");

  c_txn_pop: cover property (txn_pop && txn_count > CNT_W'(1));
  c_act_fire: cover property (act_fire ##[1:20] wr_stat);
  c_irq_rise: cover property ($rose(usb_irq_request));
  c_ta_timeout: cover property (ta_timeout);
endmodule
`default_nettype wire

// ===== verification/uifl_engine_model.sv
// Purpose: behavioural serial engine feeding events to the flag logic
// Assumes: events are one-cycle pulses launched just after a rising edge, except bus_idle_level, held for n cycles by idle_for
// Notes: levels return low between uses so stale values never linger
`default_nettype none
module uifl_engine_model
  import uifl_pkg::*;
(
  input wire logic clk_sys, // system clock
  output var uifl_stat_ev_t stat_ev, // status events
  output var uifl_err_ev_t err_ev, // error events
  output var uifl_txn_t txn_in // finished transactions
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    stat_ev = '0;
    err_ev = '0;
    txn_in = '0;
  end

  task automatic stat_pulse(input uifl_stat_ev_t e);
    @(posedge clk_sys);
    stat_ev <= e;
    @(posedge clk_sys);
    stat_ev <= '0;
  endtask

  // mask uses the error flag bit positions
  task automatic err_pulse(input logic [7:0] m);
    @(posedge clk_sys);
    err_ev <= '{stuff: m[7], partial_byte: m[3], data_crc: m[2], token_crc: m[1], pid_check: m[0], default: 1'b0};
    @(posedge clk_sys);
    err_ev <= '0;
  endtask

  // eop then bit times with no response
  task automatic turnaround(input int ticks);
    @(posedge clk_sys);
    err_ev.eop <= 1'b1;
    @(posedge clk_sys);
    err_ev.eop <= 1'b0;
    repeat (ticks) begin
      err_ev.bit_tick <= 1'b1;
      @(posedge clk_sys);
      err_ev.bit_tick <= 1'b0;
      @(posedge clk_sys);
    end
  endtask

  // response start stops the timer, so later bit times must not time out
  task automatic respond(input int ticks);
    @(posedge clk_sys);
    err_ev.resp_start <= 1'b1;
    @(posedge clk_sys);
    err_ev.resp_start <= 1'b0;
    repeat (ticks) begin
      err_ev.bit_tick <= 1'b1;
      @(posedge clk_sys);
      err_ev.bit_tick <= 1'b0;
      @(posedge clk_sys);
    end
  endtask

  task automatic idle_for(input int n);
    @(posedge clk_sys);
    stat_ev.bus_idle_level <= 1'b1;
    repeat (n) @(posedge clk_sys);
    stat_ev.bus_idle_level <= 1'b0;
  endtask

  task automatic push_txn(input uifl_token_t t, input logic [7:0] info);
    @(posedge clk_sys);
    txn_in <= '{valid: 1'b1, token: t, info: info};
    @(posedge clk_sys);
    txn_in <= '0;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Purpose: self-checking bench for the usb interrupt flag logic
// Assumes: short idle count so the idle detector fires in simulation
// Notes: every bus access leaves one quiet cycle before the next
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import uifl_pkg::*;
  localparam int unsigned SIM_IDLE = 20;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  uifl_bus_req_t bus_req = '0;
  logic [7:0] rd_data;
  uifl_stat_ev_t stat_ev;
  uifl_err_ev_t err_ev;
  uifl_txn_t txn_in;
  logic txn_fifo_full;
  logic [6:0] device_address;
  logic suspend_control;
  logic usb_irq_request;
  int bad_count = 0;
  int checked = 0;
  logic [7:0] v;
  int i;

  uifl_top #(.IDLE_CYC(SIM_IDLE), .FIFO_DEPTH(4)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req),
    .rd_data(rd_data), .stat_ev(stat_ev), .err_ev(err_ev), .txn_in(txn_in), .txn_fifo_full(txn_fifo_full),
    .device_address(device_address), .suspend_control(suspend_control), .usb_irq_request(usb_irq_request));
  uifl_engine_model eng (.clk_sys(clk_sys), .stat_ev(stat_ev), .err_ev(err_ev), .txn_in(txn_in));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    bus_req <= '0;
    #1;
    d = rd_data;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge clk_sys);
    #1;
    chk({7'h00, usb_irq_request}, {7'h00, exp});
  endtask

  task automatic end_sim;
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    end_sim();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++) rd_chk(3'(i), REG_RST);
    rd_chk(3'h7, 8'h00);
    wr(ADDR_STAT_EN, 8'hFF);
    rd_chk(ADDR_STAT_EN, STAT_IMPL_MASK);
    irq_chk(1'b0);
    eng.stat_pulse('{frame_start: 1'b1, default: 1'b0});
    rd_chk(ADDR_STAT_FLAGS, 8'h40);
    chk({7'h00, usb_irq_request}, 8'h01);
    wr(ADDR_STAT_FLAGS, 8'h00);
    irq_chk(1'b0);
    wr(ADDR_STAT_EN, 8'h00);
    eng.stat_pulse('{stall_sent: 1'b1, default: 1'b0});
    rd_chk(ADDR_STAT_FLAGS, 8'h20);
    irq_chk(1'b0);
    wr(ADDR_STAT_FLAGS, 8'h00);
    wr(ADDR_DEV_ADDR, 8'h2A);
    rd_chk(ADDR_DEV_ADDR, 8'h2A);
    eng.stat_pulse('{bus_reset: 1'b1, default: 1'b0});
    #1;
    chk({1'b0, device_address}, 8'h00);
    rd_chk(ADDR_STAT_FLAGS, 8'h01);
    wr(ADDR_STAT_FLAGS, 8'h41);
    rd_chk(ADDR_STAT_FLAGS, 8'h41);
    wr(ADDR_STAT_EN, 8'h40);
    irq_chk(1'b1);
    wr(ADDR_STAT_FLAGS, 8'h00);
    // each error except turnaround alone, enables off: flag only
    for (i = 0; i < 8; i++) begin
      if (ERR_IMPL_MASK[i] && i != BIT_TURNAROUND) begin
        eng.err_pulse(8'(1 << i));
        rd_chk(ADDR_ERR_FLAGS, 8'(1 << i));
        rd_chk(ADDR_STAT_FLAGS, 8'h00);
        wr(ADDR_ERR_FLAGS, 8'h00);
      end
    end
    eng.turnaround(TURN_BIT_LIMIT);
    rd_chk(ADDR_ERR_FLAGS, 8'h00);
    eng.turnaround(TURN_BIT_LIMIT + 1);
    rd_chk(ADDR_ERR_FLAGS, 8'h10);
    wr(ADDR_ERR_FLAGS, 8'h00);
    eng.turnaround(TURN_BIT_LIMIT);
    eng.respond(TURN_BIT_LIMIT);
    rd_chk(ADDR_ERR_FLAGS, 8'h00);
    wr(ADDR_ERR_EN, 8'hFF);
    rd_chk(ADDR_ERR_EN, ERR_IMPL_MASK);
    wr(ADDR_STAT_EN, 8'h02);
    eng.err_pulse(8'h01);
    rd_chk(ADDR_STAT_FLAGS, 8'h02);
    chk({7'h00, usb_irq_request}, 8'h01);
    wr(ADDR_STAT_FLAGS, 8'h00);
    rd_chk(ADDR_STAT_FLAGS, 8'h02);
    wr(ADDR_ERR_FLAGS, 8'hFF);
    rd_chk(ADDR_ERR_FLAGS, 8'h01);
    wr(ADDR_ERR_FLAGS, 8'h00);
    rd_chk(ADDR_STAT_FLAGS, 8'h00);
    irq_chk(1'b0);
    eng.stat_pulse('{bus_active: 1'b1, default: 1'b0});
    rd_chk(ADDR_STAT_FLAGS, 8'h00);
    eng.idle_for(SIM_IDLE + 2);
    rd_chk(ADDR_STAT_FLAGS, 8'h10);
    eng.stat_pulse('{bus_active: 1'b1, default: 1'b0});
    rd_chk(ADDR_STAT_FLAGS, 8'h14);
    wr(ADDR_STAT_FLAGS, 8'h00);
    eng.stat_pulse('{bus_active: 1'b1, default: 1'b0});
    rd_chk(ADDR_STAT_FLAGS, 8'h00);
    eng.idle_for(SIM_IDLE + 2);
    eng.stat_pulse('{bus_active: 1'b1, default: 1'b0});
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_STAT_FLAGS, 8'h00);
    rd_chk(ADDR_STAT_FLAGS, 8'h04);
    chk({7'h00, suspend_control}, 8'h01);
    wr(ADDR_CTRL, 8'h00);
    v = 8'h04;
    // firmware retries until the clear sticks
    for (i = 0; i < 10 && v[BIT_BUS_ACT]; i++) begin
      wr(ADDR_STAT_FLAGS, 8'h00);
      rd(ADDR_STAT_FLAGS, v);
    end
    chk(v, 8'h00);
    eng.push_txn(TOK_IN, 8'hA1);
    eng.push_txn(TOK_SETUP, 8'hB2);
    rd_chk(ADDR_STAT_FLAGS, 8'h08);
    rd_chk(ADDR_TXN_STATUS, 8'hA1);
    wr(ADDR_STAT_FLAGS, 8'h00);
    rd_chk(ADDR_STAT_FLAGS, 8'h08);
    rd_chk(ADDR_TXN_STATUS, 8'hB2);
    eng.push_txn(TOK_OTHER, 8'hC3);
    eng.push_txn(TOK_OUT, 8'hD4);
    eng.push_txn(TOK_OUT, 8'hE5);
    rd_chk(ADDR_TXN_STATUS, 8'hB2);
    chk({7'h00, txn_fifo_full}, 8'h01);
    wr(ADDR_STAT_FLAGS, 8'h00);
    rd_chk(ADDR_TXN_STATUS, 8'hC3);
    chk({7'h00, txn_fifo_full}, 8'h00);
    // other-token head: clear drops the flag but keeps the entry
    wr(ADDR_STAT_FLAGS, 8'h00);
    rd_chk(ADDR_STAT_FLAGS, 8'h00);
    rd_chk(ADDR_TXN_STATUS, 8'hC3);
    end_sim();
  end
endmodule
`default_nettype wire
